// *** rtl/sfx_exception_unit.sv ***
// Exception decision and result post-processing for single precision lanes
module sfx_exception_unit
    import sfx_pkg::*;
#(
    parameter int EXP_W = 12
) (
    input  wire logic              core_clk,
    input  wire logic              reset_n,
    // Register port
    input  wire logic [3:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_write,
    input  wire logic              reg_read,
    output logic      [31:0]       reg_rdata,
    // Operands on their way into the arithmetic core
    input  wire logic              opnd_valid,
    input  wire logic [31:0]       opnd_a,
    input  wire logic [31:0]       opnd_b,
    output logic                   core_opnd_valid,
    output logic      [31:0]       core_opnd_a,
    output logic      [31:0]       core_opnd_b,
    // Raw result from the arithmetic core
    input  wire logic              res_valid,
    input  wire logic              res_sign,
    input  wire logic [EXP_W-1:0]  res_exp,
    input  wire logic [52:0]       res_sig,
    input  wire logic              res_sticky,
    input  wire logic              res_special,
    input  wire logic [31:0]       res_special_bits,
    input  wire logic              res_invalid,
    input  wire logic              res_denormal,
    input  wire logic              res_zerodiv,
    // Final answer
    output logic                   out_valid,
    output logic      [31:0]       out_result,
    output logic                   out_trap,
    output logic      [5:0]        out_cause,
    output logic      [7:0]        trap_vector,
    output logic                   irq
);

    //////////////////////////////////////////////////////////////////////////
    // Registers
    logic [5:0]  exc_mask;
    logic        daz;
    logic        ftz;
    sfx_rnd_t    rnd_mode;
    logic [5:0]  status;
    logic [5:0]  irq_mask;
    logic [5:0]  last_cause;
    logic [5:0]  next_flags;
    logic [5:0]  next_cause;
    logic        next_trap;
    logic [31:0] next_result;
    logic [5:0]  status_clr;
    logic [5:0]  status_set;
    logic [31:0] ctrl_word;
    logic [31:0] last_trap_word;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            exc_mask <= SFX_MASK_RST;
            daz      <= 1'b0;
            ftz      <= 1'b0;
            rnd_mode <= SFX_RND_NEAREST;
            irq_mask <= SFX_IRQ_MASK_RST;
        end else if (reg_write && reg_addr == SFX_OFS_CTRL) begin
            exc_mask <= reg_wdata[5:0];
            daz      <= reg_wdata[SFX_CTRL_DAZ];
            ftz      <= reg_wdata[SFX_CTRL_FTZ];
            rnd_mode <= sfx_rnd_t'(reg_wdata[SFX_CTRL_RND_LO +: 2]);
        end else if (reg_write && reg_addr == SFX_OFS_IRQ_MASK) begin
            irq_mask <= reg_wdata[5:0];
        end
    end

    always_comb begin
        status_clr = 6'h00;
        if (reg_write && reg_addr == SFX_OFS_STATUS) begin
            status_clr = reg_wdata[5:0];
        end
        status_set = res_valid ? next_flags : 6'h00;
    end

    // Sticky flags; a new event wins over a write-one clear
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            status <= 6'h00;
        end else begin
            status <= (status & ~status_clr) | status_set;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            last_cause <= 6'h00;
        end else if (res_valid && next_trap) begin
            last_cause <= next_cause;
        end
    end

    // Read words built from the field positions, so the map lives once
    always_comb begin
        ctrl_word                            = 32'h00000000;
        ctrl_word[5:0]                       = exc_mask;
        ctrl_word[SFX_CTRL_DAZ]              = daz;
        ctrl_word[SFX_CTRL_FTZ]              = ftz;
        ctrl_word[SFX_CTRL_RND_LO +: 2]      = rnd_mode;
        last_trap_word                       = 32'h00000000;
        last_trap_word[5:0]                  = last_cause;
        last_trap_word[SFX_LAST_VEC_LO +: 8] = SFX_TRAP_VECTOR;
    end

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            reg_rdata <= 32'h00000000;
        end else if (!reg_read) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_addr == SFX_OFS_CTRL) begin
            reg_rdata <= ctrl_word;
        end else if (reg_addr == SFX_OFS_STATUS) begin
            reg_rdata <= {26'h0000000, status};
        end else if (reg_addr == SFX_OFS_IRQ_MASK) begin
            reg_rdata <= {26'h0000000, irq_mask};
        end else if (reg_addr == SFX_OFS_LAST_TRAP) begin
            reg_rdata <= last_trap_word;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    // Level output; stays high until software clears or masks the flag
    assign irq = |(status & irq_mask);

    //////////////////////////////////////////////////////////////////////////
    // Operand substitution
    function automatic logic [31:0] sfx_daz_fix(input logic [31:0] v,
                                                 input logic       en);
        if (en && v[30:23] == 8'h00) begin
            sfx_daz_fix = {v[31], 31'h00000000};
        end else begin
            sfx_daz_fix = v;
        end
    endfunction : sfx_daz_fix

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            core_opnd_valid <= 1'b0;
            core_opnd_a     <= 32'h00000000;
            core_opnd_b     <= 32'h00000000;
        end else begin
            core_opnd_valid <= opnd_valid;
            core_opnd_a     <= sfx_daz_fix(opnd_a, daz);
            core_opnd_b     <= sfx_daz_fix(opnd_b, daz);
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Rounding
    function automatic logic sfx_round_up(input logic     sign,
                                          input logic     lsb,
                                          input logic     guard,
                                          input logic     rest,
                                          input sfx_rnd_t mode);
        case (mode)
            SFX_RND_NEAREST: sfx_round_up = guard & (rest | lsb);
            SFX_RND_DOWN:    sfx_round_up = sign & (guard | rest);
            SFX_RND_UP:      sfx_round_up = ~sign & (guard | rest);
            default:         sfx_round_up = 1'b0;
        endcase
    endfunction : sfx_round_up

    // First rounding to 24 bits with the exponent left unbounded
    logic               g24;
    logic               r24;
    logic [24:0]        sum24;
    logic [23:0]        mant24;
    logic signed [12:0] exp24;
    logic               inexact24;
    logic               tiny;
    logic               huge;

    always_comb begin
        g24       = res_sig[28];
        r24       = (|res_sig[27:0]) | res_sticky;
        sum24     = {1'b0, res_sig[52:29]}
                    + {24'h000000, sfx_round_up(res_sign, res_sig[29], g24,
                                                r24, rnd_mode)};
        mant24    = sum24[24] ? sum24[24:1] : sum24[23:0];
        exp24     = 13'(signed'(res_exp)) + {12'h000, sum24[24]};
        inexact24 = g24 | r24;
        tiny      = !res_special && exp24 < signed'(SFX_EXP_MIN);
        huge      = !res_special && exp24 > signed'(SFX_EXP_MAX);
    end

    // Denormalisation straight from the 53-bit value
    logic signed [12:0] shift_raw;
    logic [6:0]         shift;
    logic [83:0]        den_ext;
    logic               den_rest;
    logic [23:0]        den_mant;
    logic               den_inexact;

    always_comb begin
        shift_raw = signed'(SFX_EXP_MIN) - 13'(signed'(res_exp));
        if (shift_raw > signed'({6'h00, SFX_SHIFT_CLAMP})) begin
            shift = SFX_SHIFT_CLAMP;
        end else begin
            shift = shift_raw[6:0];
        end
        den_ext     = {res_sig, 31'h00000000} >> shift;
        den_rest    = (|den_ext[58:0]) | res_sticky;
        den_inexact = den_ext[59] | den_rest;
        // one rounding of the 53-bit value
        den_mant    = den_ext[83:60]
                      + {23'h000000, sfx_round_up(res_sign, den_ext[60],
                                                  den_ext[59], den_rest,
                                                  rnd_mode)};
    end

    //////////////////////////////////////////////////////////////////////////
    // Exception decision
    logic               first_trap;
    logic               inexact;
    logic signed [12:0] scaled_exp;
    logic [30:0]        ovf_mag;
    logic [31:0]        bounded;
    logic [31:0]        scaled;

    always_comb begin
        // Overflow saturates toward zero unless rounding pulls outward
        if (rnd_mode == SFX_RND_NEAREST
            || (rnd_mode == SFX_RND_DOWN && res_sign)
            || (rnd_mode == SFX_RND_UP && !res_sign)) begin
            ovf_mag = SFX_INFINITY;
        end else begin
            ovf_mag = SFX_MAX_NORMAL;
        end
        scaled_exp = huge ? exp24 - signed'(SFX_SCALE_EXP)
                          : exp24 + signed'(SFX_SCALE_EXP);
        scaled     = {res_sign, 8'(scaled_exp + signed'(SFX_EXP_BIAS)),
                      mant24[22:0]};
        // bounded exponent, rounded to 24 bits
        bounded    = {res_sign, 8'(exp24 + signed'(SFX_EXP_BIAS)),
                      mant24[22:0]};
    end

    always_comb begin
        next_flags  = 6'h00;
        next_cause  = 6'h00;
        next_trap   = 1'b0;
        next_result = 32'h00000000;
        inexact     = 1'b0;
        next_flags[SFX_BIT_INVALID]  = res_invalid;
        // A zero divide hides the denormal of its dividend
        next_flags[SFX_BIT_DENORMAL] = res_denormal & ~res_zerodiv;
        next_flags[SFX_BIT_ZERODIV]  = res_zerodiv;
        first_trap = |(next_flags[2:0] & ~exc_mask[2:0]);
        if (first_trap) begin
            next_trap  = 1'b1;
            if (res_invalid && !exc_mask[SFX_BIT_INVALID]) begin
                next_cause[SFX_BIT_INVALID] = 1'b1;
            end else if (next_flags[SFX_BIT_DENORMAL]
                         && !exc_mask[SFX_BIT_DENORMAL]) begin
                next_cause[SFX_BIT_DENORMAL] = 1'b1;
            end else begin
                next_cause[SFX_BIT_ZERODIV] = 1'b1;
            end
        end else if (res_special) begin
            next_result = res_special_bits;
        end else if (huge && !exc_mask[SFX_BIT_OVERFLOW]) begin
            next_flags[SFX_BIT_OVERFLOW]  = 1'b1;
            next_flags[SFX_BIT_PRECISION] = inexact24;
            next_cause[SFX_BIT_OVERFLOW]  = 1'b1;
            next_trap   = 1'b1;
            next_result = scaled;
        end else if (tiny && !exc_mask[SFX_BIT_UNDERFLOW]) begin
            next_flags[SFX_BIT_UNDERFLOW] = 1'b1;
            next_flags[SFX_BIT_PRECISION] = inexact24;
            next_cause[SFX_BIT_UNDERFLOW] = 1'b1;
            next_trap   = 1'b1;
            next_result = scaled;
        end else begin
            if (huge) begin
                inexact     = 1'b1;
                next_flags[SFX_BIT_OVERFLOW] = 1'b1;
                next_result = {res_sign, ovf_mag};
            end else if (tiny && ftz) begin
                inexact     = 1'b1;
                next_flags[SFX_BIT_UNDERFLOW] = 1'b1;
                next_result = {res_sign, 31'h00000000};
            end else if (tiny) begin
                // masked underflow result, flag only if inexact
                inexact     = den_inexact;
                next_flags[SFX_BIT_UNDERFLOW] = den_inexact;
                next_result = {res_sign, 8'h00, den_mant[22:0]}
                              + {8'h00, den_mant[23], 23'h000000};
            end else begin
                inexact     = inexact24;
                next_result = bounded;
            end
            next_flags[SFX_BIT_PRECISION] = inexact;
            if (inexact && !exc_mask[SFX_BIT_PRECISION]) begin
                next_cause[SFX_BIT_PRECISION] = 1'b1;
                next_trap = 1'b1;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////
    // Answer stage
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            out_valid   <= 1'b0;
            out_result  <= 32'h00000000;
            out_trap    <= 1'b0;
            out_cause   <= 6'h00;
            trap_vector <= 8'h00;
        end else begin
            out_valid   <= res_valid;
            out_result  <= res_valid ? next_result : 32'h00000000;
            out_trap    <= res_valid & next_trap;
            out_cause   <= res_valid ? next_cause : 6'h00;
            trap_vector <= (res_valid && next_trap) ? SFX_TRAP_VECTOR
                                                    : 8'h00;
        end
    end

endmodule : sfx_exception_unit

// *** rtl/sfx_pkg.sv ***
// Constants and types of the packed floating-point exception post-processor
//////////////////////////////////////////////////////////////////////////////
// Behaviour
// - Masked inexact: bounded rounded result, precision flag set.
// - Inexact with masked overflow: overflow flag and result first.
// - Inexact with masked underflow: underflow flag and result first.
// - Unmasked inexact alone: bounded rounded result, precision flag.
// - Every unmasked exception traps through vector number 19.
// - Mask bits low to high: inv, denormal, zero-div, ovf, unf, prec.
// - Zeroing mode turns denormal operands to signed zero, no flag.
// - Operation faults first; tiny or huge only if none trapped.
// - Tiny below smallest, huge above largest normal, rounded value.
// - Unmasked over/underflow hands the scaled result to the handler.
// - Bounded result delivered only when no fault trapped and the value is neither special, huge nor tiny.
// - Tiny result shifted right into exponent range -126..+127.
// - Denormal result rounded once from the 53-bit value.
// - Unmasked inexact delivers the calculated result to the handler.
// - Flush-to-zero replaces a tiny result by zero when underflow is masked.
// - Unmasked over/underflow sets flag, precision if inexact, 2^192.
//////////////////////////////////////////////////////////////////////////////
package sfx_pkg;

    // Register offsets
    localparam logic [3:0] SFX_OFS_CTRL      = 4'h0;
    localparam logic [3:0] SFX_OFS_STATUS    = 4'h4;
    localparam logic [3:0] SFX_OFS_IRQ_MASK  = 4'h8;
    localparam logic [3:0] SFX_OFS_LAST_TRAP = 4'hc;

    // Exception bit positions, shared by masks, status and trap cause
    localparam int SFX_BIT_INVALID   = 0;
    localparam int SFX_BIT_DENORMAL  = 1;
    localparam int SFX_BIT_ZERODIV   = 2;
    localparam int SFX_BIT_OVERFLOW  = 3;
    localparam int SFX_BIT_UNDERFLOW = 4;
    localparam int SFX_BIT_PRECISION = 5;

    // Control and last-trap register fields
    localparam int SFX_CTRL_DAZ     = 6;
    localparam int SFX_CTRL_FTZ     = 7;
    localparam int SFX_CTRL_RND_LO  = 8;
    localparam int SFX_LAST_VEC_LO  = 8;

    // Reset values
    localparam logic [5:0] SFX_MASK_RST     = 6'h3f;
    localparam logic [5:0] SFX_IRQ_MASK_RST = 6'h00;

    // Trap vector and single precision format figures
    localparam logic [7:0]  SFX_TRAP_VECTOR = 8'h13;
    localparam logic [12:0] SFX_SCALE_EXP   = 13'h00c0;
    localparam logic [12:0] SFX_EXP_BIAS    = 13'h007f;
    localparam logic [12:0] SFX_EXP_MIN     = 13'h1f82;
    localparam logic [12:0] SFX_EXP_MAX     = 13'h007f;
    localparam logic [30:0] SFX_MAX_NORMAL  = 31'h7f7fffff;
    localparam logic [30:0] SFX_INFINITY    = 31'h7f800000;
    localparam logic [6:0]  SFX_SHIFT_CLAMP = 7'h3c;

    typedef enum logic [1:0] {
        SFX_RND_NEAREST = 2'b00,
        SFX_RND_DOWN    = 2'b01,
        SFX_RND_UP      = 2'b10,
        SFX_RND_ZERO    = 2'b11
    } sfx_rnd_t;

endpackage : sfx_pkg

// *** bench/sfx_exception_unit_chk.sv ***
// Port-level checker for the floating-point exception post-processor
module sfx_exception_unit_chk
    import sfx_pkg::*;
#(
    parameter int EXP_W = 12
) (
    input wire logic             core_clk,
    input wire logic             reset_n,
    input wire logic [3:0]       reg_addr,
    input wire logic [31:0]      reg_wdata,
    input wire logic             reg_write,
    input wire logic             reg_read,
    input wire logic [31:0]      reg_rdata,
    input wire logic             opnd_valid,
    input wire logic [31:0]      opnd_a,
    input wire logic [31:0]      opnd_b,
    input wire logic             core_opnd_valid,
    input wire logic [31:0]      core_opnd_a,
    input wire logic [31:0]      core_opnd_b,
    input wire logic             res_valid,
    input wire logic [EXP_W-1:0] res_exp,
    input wire logic             res_special,
    input wire logic             res_invalid,
    input wire logic             res_denormal,
    input wire logic             res_zerodiv,
    input wire logic             out_valid,
    input wire logic [31:0]      out_result,
    input wire logic             out_trap,
    input wire logic [5:0]       out_cause,
    input wire logic [7:0]       trap_vector
);
    timeunit 1ns;
    timeprecision 1ps;

    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);

    //////////////////////////////////////////////////////////////////////
    // Shadow of the control fields, so checks follow the programmed mode
    logic [5:0] masks_q;
    logic       daz_q;
    logic [1:0] rnd_q;
    logic       huge_in;

    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            masks_q <= 6'h3f;
            daz_q   <= 1'b0;
            rnd_q   <= 2'h0;
        end else if (reg_write && reg_addr == 4'h0) begin
            masks_q <= reg_wdata[5:0];
            daz_q   <= reg_wdata[6];
            rnd_q   <= reg_wdata[9:8];
        end
    end

    // Clean operation whose exponent is beyond the largest normal
    assign huge_in = res_valid && !res_special && !res_invalid &&
                     !res_denormal && !res_zerodiv && $signed(res_exp) > 127;

    //////////////////////////////////////////////////////////////////////
    chk_result_latency: assert property (res_valid |=> out_valid)
        else $error("result not answered one cycle later");
    chk_no_stray_out: assert property (out_valid |-> $past(res_valid))
        else $error("result without request");
    chk_trap_vector: assert property (
        trap_vector == (out_trap ? 8'h13 : 8'h00))
        else $error("trap vector wrong");
    chk_trap_cause: assert property (
        out_trap |-> out_valid && $onehot(out_cause))
        else $error("trap without one-hot cause");
    chk_first_fault: assert property (
        res_valid && res_invalid && !res_special && !masks_q[0]
        |=> out_trap && out_cause == 6'h01 && out_result == 32'h0)
        else $error("invalid trap not taken first");
    chk_ovf_masked: assert property (
        huge_in && masks_q[3] && rnd_q == 2'h0
        |=> out_result[30:0] == 31'h7f800000)
        else $error("masked overflow result not infinity");
    chk_ovf_trap: assert property (
        huge_in && !masks_q[3] |=> out_trap && out_cause == 6'h08)
        else $error("unmasked overflow not trapped");
    chk_opnd_pass: assert property (opnd_valid |=> core_opnd_valid)
        else $error("operand not passed on");
    chk_daz_zero: assert property (
        opnd_valid && daz_q && opnd_a[30:23] == 8'h00
        |=> core_opnd_a == ($past(opnd_a) & 32'h80000000))
        else $error("denormal operand not zeroed");
    chk_opnd_copy: assert property (opnd_valid && !daz_q
        |=> core_opnd_a == $past(opnd_a) && core_opnd_b == $past(opnd_b))
        else $error("operand altered without zeroing mode");
    chk_rdata_idle: assert property (!reg_read |=> reg_rdata == 32'h0)
        else $error("read data not idle");
endmodule : sfx_exception_unit_chk

// *** bench/test_simd_fp_exception_result.sv ***
// Self-checking bench for the floating-point exception post-processor
`define CMP(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
    fails++; $display("wrong value at %0t: got %h expected %h", \
    $time, got, exp); end end

module test_simd_fp_exception_result
    import sfx_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    logic        core_clk = 1'b0;
    logic        reset_n = 1'b0;
    logic [3:0]  reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_write = 1'b0;
    logic        reg_read = 1'b0;
    logic        opnd_valid = 1'b0;
    logic [31:0] opnd_a = 32'h0;
    logic [31:0] opnd_b = 32'h0;
    logic        res_valid = 1'b0;
    logic        res_sign = 1'b0;
    logic [11:0] res_exp = 12'h0;
    logic [52:0] res_sig = 53'h0;
    logic        res_sticky = 1'b0;
    logic [3:0]  res_flags = 4'h0;
    logic [31:0] res_bits = 32'h0;
    logic [31:0] reg_rdata, core_opnd_a, core_opnd_b, out_result;
    logic        core_opnd_valid, out_valid, out_trap, irq;
    logic [5:0]  out_cause;
    logic [7:0]  trap_vector;
    int          fails = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    localparam logic [52:0] SIG_ONE = 53'h10000000000000;
    localparam logic [52:0] SIG_LSB = 53'h10000000000001;
    localparam logic [52:0] SIG_HALF = 53'h10000020000000;
    // Masked overflow answers, by rounding mode then sign
    logic [31:0] ovf_res [8] = '{32'h7f800000, 32'hff800000, 32'h7f7fffff,
        32'hff800000, 32'h7f800000, 32'hff7fffff, 32'h7f7fffff, 32'hff7fffff};

    sfx_exception_unit u_dut (.core_clk, .reset_n, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .opnd_valid, .opnd_a, .opnd_b,
        .core_opnd_valid, .core_opnd_a, .core_opnd_b, .res_valid, .res_sign,
        .res_exp, .res_sig, .res_sticky, .res_special(res_flags[3]),
        .res_special_bits(res_bits), .res_invalid(res_flags[2]),
        .res_denormal(res_flags[1]), .res_zerodiv(res_flags[0]),
        .out_valid, .out_result, .out_trap, .out_cause, .trap_vector, .irq);

    always #5 core_clk = ~core_clk;

    // Hang guard: the whole run needs well under a thousand cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 3000) begin
            fails++;
            test_done();
        end
    end

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : test_done

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] e);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        #1;
        `CMP(reg_rdata, e)
    endtask : rd

    task automatic opnd(input logic [31:0] a, b, ea, eb);
        @(posedge core_clk);
        opnd_valid <= 1'b1;
        opnd_a <= a;
        opnd_b <= b;
        @(posedge core_clk);
        opnd_valid <= 1'b0;
        #1;
        `CMP(core_opnd_valid, 1'b1)
        `CMP(core_opnd_a, ea)
        `CMP(core_opnd_b, eb)
    endtask : opnd

    // One lane: clear flags, send, check answer and sticky flags
    task automatic run(input logic s, input logic [11:0] x,
        input logic [52:0] g, input logic k, input logic [3:0] f,
        input logic [31:0] er, input logic [5:0] ec, es);
        wr(4'h4, 32'h3f);
        @(posedge core_clk);
        res_valid <= 1'b1;
        res_sign <= s;
        res_exp <= x;
        res_sig <= g;
        res_sticky <= k;
        res_flags <= f;
        res_bits <= er;
        @(posedge core_clk);
        res_valid <= 1'b0;
        #1;
        `CMP(out_valid, 1'b1)
        `CMP(out_result, er)
        `CMP(out_trap, |ec)
        `CMP(out_cause, ec)
        `CMP(trap_vector, (|ec) ? 8'h13 : 8'h00)
        rd(4'h4, {26'h0, es});
    endtask : run

    initial begin
        repeat (12) @(posedge core_clk);
        reset_n <= 1'b1;
        rd(4'h0, 32'h3f);
        rd(4'h4, 32'h0);
        rd(4'h8, 32'h0);
        wr(4'h2, 32'hffff);
        rd(4'h2, 32'h0);
        wr(4'h0, 32'h3ff);
        rd(4'h0, 32'h3ff);
        $display("test registers done");
        wr(4'h0, 32'h7f);
        opnd(32'h80000001, 32'h3f800000, 32'h80000000, 32'h3f800000);
        opnd(32'h3f800000, 32'h007fffff, 32'h3f800000, 32'h0);
        rd(4'h4, 32'h0);
        wr(4'h0, 32'h3f);
        opnd(32'h80000001, 32'h2, 32'h80000001, 32'h2);
        $display("test operands done");
        for (int m = 0; m < 4; m++) begin
            wr(4'h0, {22'h0, m[1:0], 8'h3f});
            for (int s = 0; s < 2; s++) begin
                run(s[0], 12'h0c8, SIG_ONE, 1'b0, 4'h0, ovf_res[m*2+s],
                    6'h00, 6'h28);
            end
        end
        wr(4'h0, 32'h3f);
        run(0, 12'h0, SIG_ONE, 1, 4'h0, 32'h3f800000, 6'h0, 6'h20);
        run(0, 12'hf81, SIG_LSB, 0, 4'h0, 32'h00400000, 6'h0, 6'h30);
        run(0, 12'hf81, SIG_HALF, 0, 4'h0, 32'h00400000, 6'h0, 6'h30);
        run(0, 12'hf81, SIG_HALF, 1, 4'h0, 32'h00400001, 6'h0, 6'h30);
        $display("test masked results done");
        wr(4'h0, 32'h1f);
        run(0, 12'h0, SIG_ONE, 1, 4'h0, 32'h3f800000, 6'h20, 6'h20);
        run(0, 12'h0c8, SIG_ONE, 0, 4'h0, 32'h7f800000, 6'h20, 6'h28);
        run(1, 12'hf81, SIG_LSB, 0, 4'h0, 32'h80400000, 6'h20, 6'h30);
        wr(4'h0, 32'h37);
        run(1, 12'h0c8, SIG_ONE, 0, 4'h0, 32'hc3800000, 6'h08, 6'h08);
        run(0, 12'h0c8, SIG_ONE, 1, 4'h0, 32'h43800000, 6'h08, 6'h28);
        rd(4'hc, 32'h1308);
        wr(4'hc, 32'h0);
        rd(4'hc, 32'h1308);
        wr(4'h0, 32'h2f);
        run(0, 12'hf7e, SIG_ONE, 0, 4'h0, 32'h5e800000, 6'h10, 6'h10);
        $display("test traps done");
        wr(4'h0, 32'hbf);
        run(1, 12'hf81, SIG_LSB, 0, 4'h0, 32'h80000000, 6'h0, 6'h30);
        wr(4'h8, 32'h10);
        `CMP(irq, 1'b1)
        wr(4'h8, 32'h0);
        `CMP(irq, 1'b0)
        wr(4'h8, 32'h10);
        wr(4'h4, 32'h10);
        `CMP(irq, 1'b0)
        rd(4'h4, 32'h20);
        $display("test flush and interrupt done");
        wr(4'h0, 32'h3e);
        run(0, 12'h0, SIG_ONE, 0, 4'h5, 32'h0, 6'h01, 6'h05);
        wr(4'h0, 32'h33);
        run(0, 12'h0c8, SIG_ONE, 0, 4'h1, 32'h0, 6'h04, 6'h04);
        run(0, 12'h0, SIG_ONE, 0, 4'h8, 32'h7fc00000, 6'h0, 6'h0);
        $display("test first faults done");
        test_done();
    end
endmodule : test_simd_fp_exception_result

bind sfx_exception_unit sfx_exception_unit_chk #(.EXP_W(EXP_W)) u_chk (
    .core_clk, .reset_n, .reg_addr, .reg_wdata, .reg_write, .reg_read,
    .reg_rdata, .opnd_valid, .opnd_a, .opnd_b, .core_opnd_valid,
    .core_opnd_a, .core_opnd_b, .res_valid, .res_exp, .res_special,
    .res_invalid, .res_denormal, .res_zerodiv, .out_valid, .out_result,
    .out_trap, .out_cause, .trap_vector);
